// File: rtl/tes_pkg.sv
// package: constants, register layout and types of the event/interrupt timer block
package tes_pkg;

  // =====================================================================
  // widths
  localparam int ADDR_W  = 6;
  localparam int DATA_W  = 8;
  localparam int WORD_W  = 16;
  localparam int NUM_CMP = 3;
  localparam int PRESC_W = 10;

  // =====================================================================
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CONTROL_A       = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_B       = 6'h01;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_C       = 6'h02;
  localparam logic [ADDR_W-1:0] OFS_SPLIT_SELECT    = 6'h03;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_E_CLEAR = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_E_SET   = 6'h05;
  localparam logic [ADDR_W-1:0] OFS_BV_CLEAR        = 6'h06;
  localparam logic [ADDR_W-1:0] OFS_BV_SET          = 6'h07;
  localparam logic [ADDR_W-1:0] OFS_EVENT_CONTROL   = 6'h09;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE      = 6'h0A;
  localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS       = 6'h0B;
  localparam logic [ADDR_W-1:0] OFS_DEBUG_RUN       = 6'h0E;
  localparam logic [ADDR_W-1:0] OFS_STAGING         = 6'h0F;
  localparam logic [ADDR_W-1:0] OFS_COUNTER         = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_PERIOD          = 6'h26;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_0       = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_1       = 6'h2A;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_2       = 6'h2C;
  localparam logic [ADDR_W-1:0] OFS_PERIOD_BUF      = 6'h36;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_BUF_0   = 6'h38;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_BUF_1   = 6'h3A;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_BUF_2   = 6'h3C;

  // =====================================================================
  // field positions
  localparam int BIT_ENABLE      = 0;
  localparam int CLK_SEL_LSB     = 1;
  localparam int BIT_RUN_STANDBY = 7;
  localparam int WAVE_LSB        = 0;
  localparam int BIT_AUTO_LOCK   = 3;
  localparam int CMP_EN_LSB      = 4;
  localparam int BIT_SPLIT       = 0;
  localparam int BIT_DIR         = 0;
  localparam int BIT_LOCK        = 1;
  localparam int CMD_LSB         = 2;
  localparam int BV_PERIOD       = 0;
  localparam int BV_CMP_LSB      = 1;
  localparam int BIT_DEBUG_RUN   = 0;
  localparam int IRQ_OVF_LOW_UNDERFLOW_IRQ    = 0;
  localparam int IRQ_HIGH_UNDERFLOW_IRQ        = 1;
  localparam int IRQ_CMP_LSB     = 4;

  // writable bits per register
  localparam logic [7:0] WMASK_CONTROL_A = 8'h8F;
  localparam logic [7:0] WMASK_CONTROL_B = 8'h7F;
  localparam logic [7:0] WMASK_CONTROL_C = 8'h07;
  localparam logic [7:0] WMASK_IRQ       = 8'h73;
  localparam logic [7:0] WMASK_DEBUG     = 8'h01;

  // prescaler masks for divide by 1,2,4,8,16,64,256,1024
  localparam logic [7:0][PRESC_W-1:0] PRESC_MASK = {
    10'h3FF, 10'h0FF, 10'h03F, 10'h00F, 10'h007, 10'h003, 10'h001, 10'h000
  };

  // =====================================================================
  // enumerations
  typedef enum logic [2:0] {
    ACT_COUNT_RISE   = 3'h0,
    ACT_COUNT_ANY    = 3'h1,
    ACT_COUNT_HIGH   = 3'h2,
    ACT_UPDOWN       = 3'h3,
    ACT_RESTART_RISE = 3'h4,
    ACT_RESTART_ANY  = 3'h5,
    ACT_RESTART_HIGH = 3'h6,
    ACT_NONE         = 3'h7
  } tes_action_e;

  typedef enum logic [1:0] {
    CMD_NONE    = 2'h0,
    CMD_UPDATE  = 2'h1,
    CMD_RESTART = 2'h2,
    CMD_RESET   = 2'h3
  } tes_cmd_e;

  localparam logic [2:0] WG_FREQ      = 3'h1;
  localparam logic [2:0] WG_DS_TOP    = 3'h5;
  localparam logic [2:0] WG_DS_BOTH   = 3'h6;
  localparam logic [2:0] WG_DS_BOTTOM = 3'h7;

  // =====================================================================
  // carriers
  typedef struct packed {
    tes_action_e b_action;
    logic        b_enable;
    tes_action_e a_action;
    logic        a_enable;
  } tes_event_control_register_s;

  typedef struct packed {
    logic [7:0]                  control_a;
    logic [7:0]                  control_b;
    logic [7:0]                  control_c;
    logic                        split;
    logic                        count_down;
    logic                        lock_update;
    logic [3:0]                  buf_valid;
    tes_event_control_register_s                 event_control_register;
    logic [7:0]                  irq_enable;
    logic [7:0]                  irq_flags;
    logic [7:0]                  debug_run;
    logic [7:0]                  staging;
    logic [WORD_W-1:0]           counter;
    logic [WORD_W-1:0]           period;
    logic [NUM_CMP-1:0][WORD_W-1:0] compare;
    logic [WORD_W-1:0]           period_buf;
    logic [NUM_CMP-1:0][WORD_W-1:0] compare_buf;
    logic [PRESC_W-1:0]          presc;
    logic                        ev_a_prev;
    logic                        ev_b_prev;
  } tes_regs_s;

  localparam tes_regs_s REGS_RESET = '0;

endpackage

// File: rtl/tes_timer.sv
// timer/counter core: event inputs, interrupt flags, sleep gating, register port
//
// Functional notes
// - input A counts rising, any edge, or high
// - direction input: low counts up, high down
// - input B restarts on rising, any, or high
// - inputs act only when enabled; action field selects
// - both direction inputs ORed; up when both low
// - split mode ignores both event inputs
// - normal mode overflow flag at TOP or BOTTOM
// - normal mode compare flag per channel on match
// - split low byte underflow at BOTTOM
// - split high byte underflow at BOTTOM
// - split compare on low byte match
// - flags set whether or not enabled
// - enable bit shares flag bit position
// - request while flag and enable both set
// - standby sleep halts timer by default
// - run-in-standby bit keeps timer running
// - power-down sleep always halts timer
`timescale 1ns/1ps
`default_nettype none

module tes_timer (
  // clock and reset
  input  wire logic                      SYS_CLK,
  input  wire logic                      RESET,
  // register port
  input  wire logic [tes_pkg::ADDR_W-1:0] REG_ADDR,
  input  wire logic [tes_pkg::DATA_W-1:0] REG_WDATA,
  input  wire logic                      REG_WR,
  input  wire logic                      REG_RD,
  output logic      [tes_pkg::DATA_W-1:0] REG_RDATA,
  // event inputs from the routing network
  input  wire logic                      EVENT_INPUT_A,
  input  wire logic                      EVENT_INPUT_B,
  // sleep and debug state
  input  wire logic                      SLEEP_STANDBY,
  input  wire logic                      SLEEP_POWERDOWN,
  input  wire logic                      DEBUG_HALTED,
  // interrupt request and status
  output logic                           IRQ_REQUEST,
  output logic                           TIMER_RUNNING
);

  // =====================================================================
  // state
  tes_pkg::tes_regs_s               regs;
  tes_pkg::tes_regs_s               next_regs;
  logic [tes_pkg::DATA_W-1:0]       rdata;
  logic [tes_pkg::DATA_W-1:0]       next_rdata;

  // =====================================================================
  // helpers
  function automatic logic [15:0] merge_write(input logic [15:0] old, input logic hi,
                                              input logic [7:0] d, input logic [7:0] tmp,
                                              input logic split);
    if (split) begin
      merge_write = hi ? {d, old[7:0]} : {old[15:8], d};
    end else begin
      merge_write = hi ? {d, tmp} : old;
    end
  endfunction

  function automatic logic [7:0] step8(input logic [7:0] v, input logic [7:0] reload);
    step8 = (v == 8'h00) ? reload : v - 8'h01;
  endfunction

  // =====================================================================
  // derived controls
  logic        enabled;
  logic        halted;
  logic        active;
  logic        split;
  logic        rise_a;
  logic        any_a;
  logic        rise_b;
  logic        any_b;
  logic        a_on;
  logic        b_on;
  logic        dir_a;
  logic        dir_b;
  logic        dir_by_event;
  logic        dir_level;
  logic        a_counts;
  logic        tick;
  logic        step;
  logic        restart_ev;
  logic        going_down;
  logic [2:0]  wave;
  logic        dual;
  logic [15:0] top;
  logic [15:0] word_cur;
  logic        word_hit;
  logic        word_hi;
  logic [5:0]  word_addr;
  logic        all_bv;

  assign enabled = regs.control_a[tes_pkg::BIT_ENABLE];
  assign halted  = SLEEP_POWERDOWN
                 | (SLEEP_STANDBY & ~regs.control_a[tes_pkg::BIT_RUN_STANDBY])
                 | (DEBUG_HALTED & ~regs.debug_run[tes_pkg::BIT_DEBUG_RUN]);
  assign active  = enabled & ~halted;
  assign split   = regs.split;

  // network events share this clock, so only one stage for edge detection
  assign rise_a = EVENT_INPUT_A & ~regs.ev_a_prev;
  assign any_a  = EVENT_INPUT_A ^ regs.ev_a_prev;
  assign rise_b = EVENT_INPUT_B & ~regs.ev_b_prev;
  assign any_b  = EVENT_INPUT_B ^ regs.ev_b_prev;

  assign a_on  = ~split & regs.event_control_register.a_enable;
  assign b_on  = ~split & regs.event_control_register.b_enable;
  assign dir_a = a_on & (regs.event_control_register.a_action == tes_pkg::ACT_UPDOWN);
  assign dir_b = b_on & (regs.event_control_register.b_action == tes_pkg::ACT_UPDOWN);
  assign dir_by_event = dir_a | dir_b;
  assign dir_level    = (dir_a & EVENT_INPUT_A) | (dir_b & EVENT_INPUT_B);
  assign going_down   = dir_by_event ? dir_level : regs.count_down;

  assign a_counts = a_on & ((regs.event_control_register.a_action == tes_pkg::ACT_COUNT_RISE)
                          | (regs.event_control_register.a_action == tes_pkg::ACT_COUNT_ANY)
                          | (regs.event_control_register.a_action == tes_pkg::ACT_COUNT_HIGH));

  assign tick = active
              & ((regs.presc | ~tes_pkg::PRESC_MASK[regs.control_a[tes_pkg::CLK_SEL_LSB +: 3]])
                 == '1);

  // level counting relies on events slower than the tick
  assign step = a_counts ? (active & (
                  ((regs.event_control_register.a_action == tes_pkg::ACT_COUNT_RISE) & rise_a)
                | ((regs.event_control_register.a_action == tes_pkg::ACT_COUNT_ANY) & any_a)
                | ((regs.event_control_register.a_action == tes_pkg::ACT_COUNT_HIGH) & tick & EVENT_INPUT_A)))
              : tick;

  assign restart_ev = active & b_on & (
                  ((regs.event_control_register.b_action == tes_pkg::ACT_RESTART_RISE) & rise_b)
                | ((regs.event_control_register.b_action == tes_pkg::ACT_RESTART_ANY) & any_b)
                | ((regs.event_control_register.b_action == tes_pkg::ACT_RESTART_HIGH) & EVENT_INPUT_B));

  assign wave = regs.control_b[tes_pkg::WAVE_LSB +: 3];
  assign dual = (wave == tes_pkg::WG_DS_TOP) | (wave == tes_pkg::WG_DS_BOTH)
              | (wave == tes_pkg::WG_DS_BOTTOM);
  assign top  = (wave == tes_pkg::WG_FREQ) ? regs.compare[0] : regs.period;

  // all enabled channels have fresh buffers
  assign all_bv = &(regs.buf_valid[tes_pkg::BV_CMP_LSB +: tes_pkg::NUM_CMP]
                  | ~regs.control_b[tes_pkg::CMP_EN_LSB +: tes_pkg::NUM_CMP]);

  // 16-bit register select
  assign word_addr = {REG_ADDR[5:1], 1'b0};
  assign word_hi   = REG_ADDR[0];
  always_comb begin
    word_hit = 1'b1;
    word_cur = 16'h0000;
    case (word_addr)
      tes_pkg::OFS_COUNTER:       word_cur = regs.counter;
      tes_pkg::OFS_PERIOD:        word_cur = regs.period;
      tes_pkg::OFS_COMPARE_0:     word_cur = regs.compare[0];
      tes_pkg::OFS_COMPARE_1:     word_cur = regs.compare[1];
      tes_pkg::OFS_COMPARE_2:     word_cur = regs.compare[2];
      tes_pkg::OFS_PERIOD_BUF:    word_cur = regs.period_buf;
      tes_pkg::OFS_COMPARE_BUF_0: word_cur = regs.compare_buf[0];
      tes_pkg::OFS_COMPARE_BUF_1: word_cur = regs.compare_buf[1];
      tes_pkg::OFS_COMPARE_BUF_2: word_cur = regs.compare_buf[2];
      default:                    word_hit = 1'b0;
    endcase
  end

  // =====================================================================
  // next state
  logic [7:0]  irq_set;
  logic [7:0]  flag_clr;
  logic [15:0] new_cnt;
  logic        wrapped;
  logic        do_update;
  logic [15:0] wval;
  tes_pkg::tes_cmd_e cmd;

  always_comb begin
    next_regs = regs;
    next_rdata = 8'h00;
    irq_set   = 8'h00;
    flag_clr  = 8'h00;
    new_cnt   = regs.counter;
    wrapped   = 1'b0;
    do_update = 1'b0;
    wval      = 16'h0000;
    cmd       = tes_pkg::CMD_NONE;

    next_regs.ev_a_prev = EVENT_INPUT_A;
    next_regs.ev_b_prev = EVENT_INPUT_B;
    next_regs.presc = active ? regs.presc + 10'h001 : regs.presc;
    if (!enabled) begin
      next_regs.presc = '0;
    end
    if (dir_by_event) begin
      next_regs.count_down = dir_level;
    end

    // ----- counting
    if (split) begin
      if (tick) begin
        new_cnt[7:0]  = step8(regs.counter[7:0], regs.period[7:0]);
        new_cnt[15:8] = step8(regs.counter[15:8], regs.period[15:8]);
        irq_set[tes_pkg::IRQ_OVF_LOW_UNDERFLOW_IRQ] = (regs.counter[7:0] == 8'h00);
        irq_set[tes_pkg::IRQ_HIGH_UNDERFLOW_IRQ]     = (regs.counter[15:8] == 8'h00);
        for (int i = 0; i < tes_pkg::NUM_CMP; i++) begin
          irq_set[tes_pkg::IRQ_CMP_LSB + i] = (new_cnt[7:0] == regs.compare[i][7:0]);
        end
      end
    end else if (step) begin
      if (dual) begin
        if (!going_down && regs.counter == top) begin
          new_cnt = regs.counter - 16'h0001;
          next_regs.count_down = 1'b1;
          irq_set[tes_pkg::IRQ_OVF_LOW_UNDERFLOW_IRQ] = (wave != tes_pkg::WG_DS_BOTTOM);
        end else if (going_down && regs.counter == 16'h0000) begin
          new_cnt = 16'h0001;
          next_regs.count_down = 1'b0;
          wrapped = 1'b1;
          irq_set[tes_pkg::IRQ_OVF_LOW_UNDERFLOW_IRQ] = (wave != tes_pkg::WG_DS_TOP);
        end else begin
          new_cnt = going_down ? regs.counter - 16'h0001 : regs.counter + 16'h0001;
        end
      end else if (!going_down) begin
        wrapped = (regs.counter == top);
        new_cnt = wrapped ? 16'h0000 : regs.counter + 16'h0001;
        irq_set[tes_pkg::IRQ_OVF_LOW_UNDERFLOW_IRQ] = wrapped;
      end else begin
        wrapped = (regs.counter == 16'h0000);
        new_cnt = wrapped ? top : regs.counter - 16'h0001;
        irq_set[tes_pkg::IRQ_OVF_LOW_UNDERFLOW_IRQ] = wrapped;
      end
      for (int i = 0; i < tes_pkg::NUM_CMP; i++) begin
        irq_set[tes_pkg::IRQ_CMP_LSB + i] = (new_cnt == regs.compare[i]);
      end
    end
    next_regs.counter = new_cnt;

    if (restart_ev) begin
      next_regs.counter    = 16'h0000;
      next_regs.count_down = 1'b0;
      next_regs.presc      = '0;
    end

    // ----- register writes
    if (REG_WR) begin
      case (REG_ADDR)
        tes_pkg::OFS_CONTROL_A:    next_regs.control_a = REG_WDATA & tes_pkg::WMASK_CONTROL_A;
        tes_pkg::OFS_CONTROL_B:    next_regs.control_b = REG_WDATA & tes_pkg::WMASK_CONTROL_B;
        tes_pkg::OFS_CONTROL_C:    next_regs.control_c = REG_WDATA & tes_pkg::WMASK_CONTROL_C;
        tes_pkg::OFS_SPLIT_SELECT: next_regs.split = REG_WDATA[tes_pkg::BIT_SPLIT];
        tes_pkg::OFS_CONTROL_E_CLEAR: begin
          if (REG_WDATA[tes_pkg::BIT_DIR]) next_regs.count_down = 1'b0;
          if (REG_WDATA[tes_pkg::BIT_LOCK]) next_regs.lock_update = 1'b0;
        end
        tes_pkg::OFS_CONTROL_E_SET: begin
          if (REG_WDATA[tes_pkg::BIT_DIR]) next_regs.count_down = 1'b1;
          if (REG_WDATA[tes_pkg::BIT_LOCK]) next_regs.lock_update = 1'b1;
          cmd = tes_pkg::tes_cmd_e'(REG_WDATA[tes_pkg::CMD_LSB +: 2]);
        end
        tes_pkg::OFS_BV_CLEAR:      next_regs.buf_valid = regs.buf_valid & ~REG_WDATA[3:0];
        tes_pkg::OFS_BV_SET:        next_regs.buf_valid = regs.buf_valid | REG_WDATA[3:0];
        tes_pkg::OFS_EVENT_CONTROL: next_regs.event_control_register = tes_pkg::tes_event_control_register_s'(REG_WDATA);
        tes_pkg::OFS_IRQ_ENABLE:    next_regs.irq_enable = REG_WDATA & tes_pkg::WMASK_IRQ;
        tes_pkg::OFS_IRQ_FLAGS:     flag_clr = REG_WDATA & tes_pkg::WMASK_IRQ;
        tes_pkg::OFS_DEBUG_RUN:     next_regs.debug_run = REG_WDATA & tes_pkg::WMASK_DEBUG;
        tes_pkg::OFS_STAGING:       next_regs.staging = REG_WDATA;
        default: begin
          if (word_hit) begin
            wval = merge_write(word_cur, word_hi, REG_WDATA, regs.staging, split);
            if (!split && !word_hi) begin
              next_regs.staging = REG_WDATA;
            end
            case (word_addr)
              tes_pkg::OFS_COUNTER:    next_regs.counter = wval;
              tes_pkg::OFS_PERIOD:     next_regs.period = wval;
              tes_pkg::OFS_COMPARE_0:  next_regs.compare[0] = wval;
              tes_pkg::OFS_COMPARE_1:  next_regs.compare[1] = wval;
              tes_pkg::OFS_COMPARE_2:  next_regs.compare[2] = wval;
              tes_pkg::OFS_PERIOD_BUF: begin
                next_regs.period_buf = wval;
                next_regs.buf_valid[tes_pkg::BV_PERIOD] = 1'b1;
              end
              tes_pkg::OFS_COMPARE_BUF_0: begin
                next_regs.compare_buf[0] = wval;
                next_regs.buf_valid[tes_pkg::BV_CMP_LSB] = 1'b1;
              end
              tes_pkg::OFS_COMPARE_BUF_1: begin
                next_regs.compare_buf[1] = wval;
                next_regs.buf_valid[tes_pkg::BV_CMP_LSB + 1] = 1'b1;
              end
              default: begin
                next_regs.compare_buf[2] = wval;
                next_regs.buf_valid[tes_pkg::BV_CMP_LSB + 2] = 1'b1;
              end
            endcase
          end
        end
      endcase
    end

    // ----- register reads, data in the next cycle
    if (REG_RD) begin
      case (REG_ADDR)
        tes_pkg::OFS_CONTROL_A:       next_rdata = regs.control_a;
        tes_pkg::OFS_CONTROL_B:       next_rdata = regs.control_b;
        tes_pkg::OFS_CONTROL_C:       next_rdata = regs.control_c;
        tes_pkg::OFS_SPLIT_SELECT:    next_rdata = {7'h00, regs.split};
        tes_pkg::OFS_CONTROL_E_CLEAR,
        tes_pkg::OFS_CONTROL_E_SET:   next_rdata = {6'h00, regs.lock_update, regs.count_down};
        tes_pkg::OFS_BV_CLEAR,
        tes_pkg::OFS_BV_SET:          next_rdata = {4'h0, regs.buf_valid};
        tes_pkg::OFS_EVENT_CONTROL:   next_rdata = regs.event_control_register;
        tes_pkg::OFS_IRQ_ENABLE:      next_rdata = regs.irq_enable;
        tes_pkg::OFS_IRQ_FLAGS:       next_rdata = regs.irq_flags;
        tes_pkg::OFS_DEBUG_RUN:       next_rdata = regs.debug_run;
        tes_pkg::OFS_STAGING:         next_rdata = regs.staging;
        default: begin
          if (word_hit) begin
            if (split) begin
              next_rdata = word_hi ? word_cur[15:8] : word_cur[7:0];
            end else if (word_hi) begin
              next_rdata = regs.staging;
            end else begin
              next_rdata = word_cur[7:0];
              next_regs.staging = word_cur[15:8];
            end
          end
        end
      endcase
    end

    // ----- commands and buffered update
    if (cmd == tes_pkg::CMD_RESTART) begin
      next_regs.counter    = 16'h0000;
      next_regs.count_down = 1'b0;
      next_regs.presc      = '0;
    end
    // buffers are unused in split mode
    do_update = ~split & ((wrapped & ~regs.lock_update) | (cmd == tes_pkg::CMD_UPDATE));
    if (do_update) begin
      if (regs.buf_valid[tes_pkg::BV_PERIOD]) next_regs.period = regs.period_buf;
      for (int i = 0; i < tes_pkg::NUM_CMP; i++) begin
        if (regs.buf_valid[tes_pkg::BV_CMP_LSB + i]) next_regs.compare[i] = regs.compare_buf[i];
      end
      next_regs.buf_valid = 4'h0;
    end
    if (regs.control_b[tes_pkg::BIT_AUTO_LOCK]) begin
      next_regs.lock_update = do_update | ~all_bv;
    end

    // flags: a hardware set wins over a software clear
    next_regs.irq_flags = (regs.irq_flags & ~flag_clr) | irq_set;

    // hard reset only while stopped
    if (cmd == tes_pkg::CMD_RESET && !enabled) begin
      next_regs = tes_pkg::REGS_RESET;
      next_regs.ev_a_prev = EVENT_INPUT_A;
      next_regs.ev_b_prev = EVENT_INPUT_B;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      regs  <= tes_pkg::REGS_RESET;
      rdata <= 8'h00;
    end else begin
      regs  <= next_regs;
      rdata <= next_rdata;
    end
  end

  // =====================================================================
  // outputs
  assign REG_RDATA     = rdata;
  assign IRQ_REQUEST   = |(regs.irq_flags & regs.irq_enable);
  assign TIMER_RUNNING = active;

endmodule

`default_nettype wire

// File: sim/tes_chk.sv
// checker: port-level assertions for the timer block
`timescale 1ns/1ps
`default_nettype none
module tes_chk (
  // clock and reset
  input wire logic       SYS_CLK,
  input wire logic       RESET,
  // register port
  input wire logic [5:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  // sleep, debug and status
  input wire logic       SLEEP_STANDBY,
  input wire logic       SLEEP_POWERDOWN,
  input wire logic       DEBUG_HALTED,
  input wire logic       IRQ_REQUEST,
  input wire logic       TIMER_RUNNING
);
  logic [7:0] ctl_a;
  logic [7:0] ien;
  // =====================================================================
  // shadows; register-reset command is not followed
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ctl_a <= 8'h00;
      ien   <= 8'h00;
    end else if (REG_WR) begin
      if (REG_ADDR == 6'h00) ctl_a <= REG_WDATA & 8'h8F;
      if (REG_ADDR == 6'h0A) ien <= REG_WDATA & 8'h73;
    end
  end
  // =====================================================================
  // assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  sequence s_ien_wr; REG_WR && REG_ADDR == 6'h0A; endsequence
  sequence s_ien_rd; REG_RD && REG_ADDR == 6'h0A; endsequence
  a_ien_rb: assert property (s_ien_wr ##2 s_ien_rd |=> REG_RDATA == ien)
    else $error("irq enable readback");
  a_irq_en: assert property (IRQ_REQUEST |-> ien != 8'h00)
    else $error("request without enable");
  a_irq_hold: assert property (IRQ_REQUEST && !(REG_WR && REG_ADDR[5:1] == 5'h05)
    |=> IRQ_REQUEST)
    else $error("request dropped");
  a_irq_off: assert property (s_ien_wr and REG_WDATA == 8'h00 |=> !IRQ_REQUEST)
    else $error("request while disabled");
  a_pd_halt: assert property (SLEEP_POWERDOWN |-> !TIMER_RUNNING)
    else $error("runs in power-down");
  a_sb_halt: assert property (SLEEP_STANDBY && !ctl_a[7] |-> !TIMER_RUNNING)
    else $error("runs in standby");
  a_sb_run: assert property (SLEEP_STANDBY && ctl_a[7] && ctl_a[0] && !SLEEP_POWERDOWN
    && !DEBUG_HALTED |-> TIMER_RUNNING)
    else $error("halted in standby");
  a_rd_hole: assert property (REG_RD && REG_ADDR == 6'h08 |=> REG_RDATA == 8'h00)
    else $error("unmapped read");
endmodule
bind tes_timer tes_chk u_chk (.SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .SLEEP_STANDBY(SLEEP_STANDBY), .SLEEP_POWERDOWN(SLEEP_POWERDOWN),
  .DEBUG_HALTED(DEBUG_HALTED), .IRQ_REQUEST(IRQ_REQUEST), .TIMER_RUNNING(TIMER_RUNNING));
`default_nettype wire

// File: sim/tes_evnet.sv
// partner: event routing source and interrupt request watcher
`timescale 1ns/1ps
`default_nettype none
module tes_evnet (
  // clock
  input wire logic clk,
  // interrupt side
  input wire logic irq,
  // event lines
  output var logic ev_a,
  output var logic ev_b
);
  int   irq_edges;
  logic irq_q;
  initial begin
    ev_a = 1'b0;
    ev_b = 1'b0;
    irq_q = 1'b0;
    irq_edges = 0;
  end
  always @(posedge clk) begin
    irq_q <= irq;
    if (irq && !irq_q) irq_edges <= irq_edges + 1;
  end
  task automatic level(input logic a, input logic b);
    ev_a <= a;
    ev_b <= b;
  endtask
  task automatic pulse(input logic a, input logic b, input int n, input int w);
    repeat (n) begin
      level(a, b);
      repeat (w) @(posedge clk);
      level(1'b0, 1'b0);
      // low gap keeps events slower than ticks
      repeat (2) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// File: sim/test_tes_timer.sv
// testbench: register, event, interrupt and sleep scenarios
`timescale 1ns/1ps
`default_nettype none
module test_tes_timer;
  logic       clk, reset, wr, rd, ev_a, ev_b, sb, pd, dbg, irq, run;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, b;
  logic [15:0] v;
  int         n_mismatch, checks;
  logic [5:0] ra [6] = '{6'h01, 6'h02, 6'h0E, 6'h08, 6'h0A, 6'h09};
  logic [7:0] rm [6] = '{8'h7F, 8'h07, 8'h01, 8'h00, 8'h73, 8'hFF};
  logic [7:0] ce [4] = '{8'h01, 8'h03, 8'h05, 8'h91};
  logic [7:0] cx [4] = '{8'h03, 8'h09, 8'h0D, 8'h00};
  logic [7:0] de [6] = '{8'h07, 8'h06, 8'h07, 8'h77, 8'h77, 8'h07};
  logic [3:0] dv [6] = '{4'h5, 4'h1, 4'h0, 4'h3, 4'h0, 4'hC};
  logic [7:0] sa [5] = '{8'h01, 8'h81, 8'h81, 8'h81, 8'h81};
  logic [3:0] sl [5] = '{4'h8, 4'h9, 4'hC, 4'h2, 4'h1};
  tes_timer u_tes_timer (.SYS_CLK(clk), .RESET(reset), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .EVENT_INPUT_A(ev_a), .EVENT_INPUT_B(ev_b),
    .SLEEP_STANDBY(sb), .SLEEP_POWERDOWN(pd), .DEBUG_HALTED(dbg), .IRQ_REQUEST(irq),
    .TIMER_RUNNING(run));
  tes_evnet u_tes_evnet (.clk(clk), .irq(irq), .ev_a(ev_a), .ev_b(ev_b));
  initial clk = 1'b0;
  always #2 clk = ~clk;
  // =====================================================================
  // tasks
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd8(input logic [5:0] a, output logic [7:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk) d = rdata;
    @(posedge clk);
  endtask
  task automatic wr16(input logic [5:0] a, input logic [15:0] d);
    wr8(a, d[7:0]);
    wr8(a + 6'h01, d[15:8]);
  endtask
  task automatic rd16(input logic [5:0] a, output logic [15:0] d);
    rd8(a, d[7:0]);
    rd8(a + 6'h01, d[15:8]);
  endtask
  task automatic final_report;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // =====================================================================
  // watchdog, far above the few hundred cycles the tests need
  initial begin
    #20000;
    n_mismatch++;
    final_report;
  end
  // =====================================================================
  // main sequence
  initial begin
    {reset, wr, rd, addr, wdata, sb, pd, dbg} = {1'b1, 19'h00000};
    n_mismatch = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      rd8(i[5:0], b);
      cmp(b, 16'h0000);
    end
    for (int i = 0; i < 6; i++) begin
      wr8(ra[i], 8'hFF);
      rd8(ra[i], b);
      cmp(b, rm[i]);
      wr8(ra[i], 8'h00);
    end
    wr16(6'h26, 16'h1234);
    rd16(6'h26, v);
    cmp(v, 16'h1234);
    rd8(6'h0F, b);
    cmp(b, 16'h0012);
    // event counting and restart; counter holds between events
    wr16(6'h26, 16'h00FF);
    wr8(6'h09, 8'h01);
    wr8(6'h00, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr8(6'h09, ce[i]);
      u_tes_evnet.pulse(i != 3, i == 3, (i < 2) ? 3 : 1, (i == 2) ? 4 : 1);
      rd16(6'h20, v);
      cmp(v, cx[i]);
    end
    // overflow and compare flags, then the request
    wr8(6'h00, 8'h00);
    wr8(6'h09, 8'h00);
    wr16(6'h26, 16'h0003);
    wr16(6'h28, 16'h0002);
    wr16(6'h20, 16'h0000);
    wr8(6'h0B, 8'hFF);
    wr8(6'h00, 8'h01);
    repeat (12) @(posedge clk);
    wr8(6'h00, 8'h00);
    rd8(6'h0B, b);
    cmp(b, 16'h0071);
    cmp(irq, 16'h0000);
    wr8(6'h0A, 8'h02);
    cmp(irq, 16'h0000);
    wr8(6'h0A, 8'h10);
    cmp(irq, 16'h0001);
    wr8(6'h0B, 8'h10);
    cmp(irq, 16'h0000);
    rd8(6'h0B, b);
    cmp(b, 16'h0061);
    cmp(u_tes_evnet.irq_edges, 16'h0001);
    // direction from event levels
    wr8(6'h00, 8'h01);
    for (int i = 0; i < 6; i++) begin
      wr8(6'h03, {7'h00, dv[i][3]});
      wr8(6'h09, de[i]);
      u_tes_evnet.level(dv[i][2], dv[i][1]);
      repeat (2) @(posedge clk);
      rd8(6'h04, b);
      cmp(b & 8'h01, dv[i][0]);
    end
    rd8(6'h0B, b);
    cmp(b & 8'h02, 16'h0002);
    wr8(6'h03, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr8(6'h00, sa[i]);
      {sb, pd, dbg} <= sl[i][3:1];
      @(negedge clk);
      cmp(run, sl[i][0]);
      @(posedge clk);
    end
    final_report;
  end
endmodule
`default_nettype wire
